// >>> gtc_far_model.sv
/*
  Far-side model: the external count line and the crystal clock.
  Assumes the bench calls send_pulses from its own sequence.
*/
`timescale 1ns/1ps
module gtc_far_model (
  input wire logic clk_in,
  input wire logic xtal_en_in,
  output logic ext_out,
  output logic xtal_out
);
  ////////////////////////////////////////////////////////////
  // Count line idles high, so each pulse is a fall then a rise
  initial begin
    ext_out = 1'b1;
    xtal_out = 1'b0;
  end
  // Crystal toggles only while enabled, else rests low
  always begin
    #40;
    xtal_out = xtal_en_in ? ~xtal_out : 1'b0;
  end
  // Sends n pulses, each four clocks high then four low, ending high
  task automatic send_pulses(input int n);
    repeat (n) begin
      repeat (4) @(negedge clk_in);
      ext_out = 1'b0;
      repeat (4) @(negedge clk_in);
      ext_out = 1'b1;
    end
  endtask
endmodule

// >>> gtc_pkg.sv
/*
  Constants and carrier types for the gated 16-bit timer/counter.
  Assumes a single 200 MHz clock; all control bits arrive as plain ports.
*/
package gtc_pkg;
  // Instruction clock is the system clock divided by four
  localparam int GTC_INSTR_DIV = 4;
  // Prescale field encodings
  localparam logic [1:0] GTC_PS_DIV1 = 2'h0;
  localparam logic [1:0] GTC_PS_DIV2 = 2'h1;
  localparam logic [1:0] GTC_PS_DIV4 = 2'h2;
  localparam logic [1:0] GTC_PS_DIV8 = 2'h3;
  // Reset values
  localparam logic [15:0] GTC_COUNT_RST = 16'h0000;
  localparam logic [2:0] GTC_PRE_RST = 3'h0;
  // Control bits travel together
  typedef struct packed {
    logic gate_invert;
    logic gate_enable;
    logic [1:0] prescale_select;
    logic crystal_osc_enable;
    logic sync_disable;
    logic source_select;
    logic counter_on;
  } gtc_ctrl_t;
  // Byte write strobe with its data
  typedef struct packed {
    logic wr_high;
    logic wr_low;
    logic [7:0] data;
  } gtc_write_t;
endpackage

// >>> gtc_timer.sv
/*
  Gated 16-bit timer/counter core.
  Assumes all inputs synchronous to clk_in; the external count input is
  sampled at the system rate and the crystal clock arrives as a level.
*/
`timescale 1ns/1ps
module gtc_timer
  import gtc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire gtc_ctrl_t ctrl_in,
  input wire gtc_write_t wr_in,
  input wire logic gate_source_select_in,
  input wire logic gate_input_pin_in,
  input wire logic comparator_output_in,
  input wire logic ext_count_input_in,
  input wire logic crystal_clk_in,
  input wire logic internal_osc_in,
  input wire logic sleep_in,
  input wire logic flag_clear_in,
  input wire logic [1:0] pin_direction_bits_in,
  input wire logic [1:0] pin_data_in,
  output logic [7:0] count_high_byte_out,
  output logic [7:0] count_low_byte_out,
  output logic overflow_flag_out,
  output logic wake_out,
  output logic crystal_running_out,
  output logic [1:0] pin_direction_bits_out,
  output logic [1:0] pin_data_out
);
  ////////////////////////////////////////////////////////////////////////
  // Edge-tracking states of the external input
  typedef enum logic [1:0] {
    GTC_ARM = 2'b00,
    GTC_LOW = 2'b01,
    GTC_HIGH = 2'b10
  } gtc_edge_t;

  logic [15:0] count_q, count_d;           // Counter pair
  logic [2:0] pre_q, pre_d;                // Hidden prescale counter
  logic [1:0] phase_q;                     // Instruction clock divider
  logic sync1_q, sync2_q, sync3_q;         // Input synchroniser chain
  logic async_q;                           // Unsynchronised previous level
  gtc_edge_t edge_q, edge_d;               // Falling-before-rising tracker
  logic flag_q;                            // Overflow flag
  logic wake_q;                            // Wake request
  logic xtal_q;                            // Crystal allowed and enabled
  logic [7:0] rd_high_q, rd_low_q;         // Read snapshot
  logic [1:0] dir_q, dat_q;                // Port pin override outputs

  // Prescale terminal count per field value
  function automatic logic [2:0] gtc_pre_max(input logic [1:0] sel);
    case (sel)
      GTC_PS_DIV8: gtc_pre_max = 3'h7;
      GTC_PS_DIV4: gtc_pre_max = 3'h3;
      GTC_PS_DIV2: gtc_pre_max = 3'h1;
      default: gtc_pre_max = 3'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Source selection and gating
  wire xtal_ok = internal_osc_in;
  wire xtal_on = ctrl_in.crystal_osc_enable & xtal_ok;
  wire ext_raw = xtal_on ? crystal_clk_in : ext_count_input_in;
  // Switching between synchronised and direct sampling swaps the source of the
  // previous level in the edge detector, so one count may be dropped or added.
  // Software stops the counter before writing it while in direct mode.
  wire use_async = ctrl_in.source_select & ctrl_in.sync_disable;
  wire ext_lvl = use_async ? ext_raw : sync2_q;
  wire ext_prev = use_async ? async_q : sync3_q;
  wire ext_rise = ext_lvl & ~ext_prev;
  wire ext_fall = ~ext_lvl & ext_prev;
  wire ext_ok = (edge_q != GTC_ARM);
  wire sync_live = ~sleep_in | use_async;
  wire ext_tick = ext_rise & ext_ok & sync_live;
  wire int_tick = (phase_q == 2'(GTC_INSTR_DIV - 1)) & ~sleep_in;
  wire src_tick = ctrl_in.source_select ? ext_tick : int_tick;
  wire gate_src = gate_source_select_in ? comparator_output_in
                                        : gate_input_pin_in;
  wire gate_act = ~(gate_src ^ ctrl_in.gate_invert);
  wire gate_ok = ~ctrl_in.gate_enable | gate_act;
  wire run = ctrl_in.counter_on & gate_ok;
  wire pre_tick = run & src_tick;
  wire pre_done = (pre_q >= gtc_pre_max(ctrl_in.prescale_select));
  wire inc = pre_tick & pre_done;
  wire any_wr = wr_in.wr_high | wr_in.wr_low;
  wire roll = inc & (count_q == 16'hffff) & ~any_wr;

  ////////////////////////////////////////////////////////////////////////
  // Next-state decode
  always_comb begin
    count_d = inc ? count_q + 16'h0001 : count_q;
    // A byte write wins over an increment in the byte it writes
    if (wr_in.wr_high) begin
      count_d[15:8] = wr_in.data;
    end
    if (wr_in.wr_low) begin
      count_d[7:0] = wr_in.data;
    end
    if (any_wr) begin
      pre_d = GTC_PRE_RST;
    end else if (pre_tick) begin
      pre_d = pre_done ? GTC_PRE_RST : pre_q + 3'h1;
    end else begin
      pre_d = pre_q;
    end
    // Need a low level before the first rise counts
    case (edge_q)
      GTC_ARM: edge_d = (ext_fall | (ext_lvl == 1'b0 & ext_prev == 1'b0)) ? GTC_LOW : GTC_ARM;
      GTC_LOW: edge_d = ext_rise ? GTC_HIGH : GTC_LOW;
      GTC_HIGH: edge_d = ext_fall ? GTC_LOW : GTC_HIGH;
      default: edge_d = GTC_ARM;
    endcase
    if (!ctrl_in.source_select || !ctrl_in.counter_on) begin
      edge_d = GTC_ARM;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter, prescaler and divider
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_q <= GTC_COUNT_RST;
      pre_q <= GTC_PRE_RST;
      phase_q <= 2'h0;
      edge_q <= GTC_ARM;
    end else begin
      count_q <= count_d;
      pre_q <= pre_d;
      phase_q <= phase_q + 2'h1;
      edge_q <= edge_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchroniser; first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      async_q <= 1'b0;
    end else begin
      sync1_q <= ext_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      async_q <= ext_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Overflow flag: a rollover beats a same-cycle clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flag_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      flag_q <= roll | (flag_q & ~flag_clear_in);
      wake_q <= roll & sleep_in & use_async;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered read view and pin overrides
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_high_q <= 8'h00;
      rd_low_q <= 8'h00;
      xtal_q <= 1'b0;
      dir_q <= 2'h3;
      dat_q <= 2'h0;
    end else begin
      rd_high_q <= count_d[15:8];
      rd_low_q <= count_d[7:0];
      xtal_q <= xtal_on;
      dir_q <= xtal_on ? 2'h3 : pin_direction_bits_in;
      dat_q <= xtal_on ? 2'h0 : pin_data_in;
    end
  end

  assign count_high_byte_out = rd_high_q;
  assign count_low_byte_out = rd_low_q;
  assign overflow_flag_out = flag_q;
  assign wake_out = wake_q;
  assign crystal_running_out = xtal_q;
  assign pin_direction_bits_out = dir_q;
  assign pin_data_out = dat_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence gtc_max_inc_s;
    inc && count_q == 16'hffff && !any_wr;
  endsequence

  roll_sets_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
    gtc_max_inc_s |=> flag_q && count_q == 16'h0000)
    else $error("rollover did not set flag");
  flag_holds_a: assert property (@(posedge clk_in) disable iff (rst_in)
    flag_q && !flag_clear_in |=> flag_q)
    else $error("flag dropped without clear");
  write_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_in.wr_low |=> count_q[7:0] == $past(wr_in.data))
    else $error("low byte write lost");
  write_clr_pre_a: assert property (@(posedge clk_in) disable iff (rst_in)
    any_wr |=> pre_q == 3'h0)
    else $error("prescaler not cleared");
  off_holds_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !ctrl_in.counter_on && !any_wr |=> $stable(count_q))
    else $error("counter moved while off");
  gate_holds_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl_in.gate_enable && !gate_act && !any_wr |=> $stable(count_q) && $stable(pre_q))
    else $error("counter moved with gate closed");
  no_arm_count_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl_in.source_select && edge_q == GTC_ARM && !any_wr |=> $stable(count_q))
    else $error("counted before falling edge");
  pre_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
    pre_tick && pre_done && !any_wr |=> pre_q == 3'h0)
    else $error("prescaler out of range");
  pin_force_a: assert property (@(posedge clk_in) disable iff (rst_in)
    xtal_on |=> pin_direction_bits_out == 2'h3 && pin_data_out == 2'h0)
    else $error("pins not forced with crystal on");

  // The checks below cover stepping, sources, sleep, gating and the pin view.
  // Each one but read_view_a is written so that a broken term in the datapath would trip it,
  // not only the flop that carries the final result.

  // One qualified increment with no write in the same cycle
  sequence gtc_step_s;
    inc && !any_wr;
  endsequence

  // Rollover while asleep with direct sampling
  sequence gtc_sleep_roll_s;
    gtc_max_inc_s ##0 sleep_in && use_async;
  endsequence

  // Counter moves by exactly one per qualified tick
  inc_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
    gtc_step_s |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter did not step by one");

  // High byte write lands at once
  write_high_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_in.wr_high |=> count_q[15:8] == $past(wr_in.data))
    else $error("high byte write lost");

  // Internal source only ticks on the last phase of the divider
  int_phase_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !ctrl_in.source_select && !any_wr && phase_q != 2'h3 |=> $stable(count_q))
    else $error("internal count off phase");

  // External source only moves on a rising edge
  ext_edge_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl_in.source_select && !ext_rise && !any_wr |=> $stable(count_q))
    else $error("external count without rising edge");

  // Synchronised and internal counting freeze in sleep
  sync_sleep_a: assert property (@(posedge clk_in) disable iff (rst_in)
    sleep_in && !use_async && !any_wr |=> $stable(count_q))
    else $error("counted asleep while synchronised");

  // Rollover in sleep with direct sampling raises wake
  wake_roll_a: assert property (@(posedge clk_in) disable iff (rst_in)
    gtc_sleep_roll_s |=> wake_out)
    else $error("no wake on sleeping rollover");

  // Crystal stays off unless the internal oscillator runs the system
  xtal_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !internal_osc_in |=> !crystal_running_out)
    else $error("crystal enabled without internal oscillator");

  // Read view always matches the counter
  read_view_a: assert property (@(posedge clk_in) disable iff (rst_in)
    {count_high_byte_out, count_low_byte_out} == count_q)
    else $error("read view differs from counter");

  // Rollover beats a clear in the same cycle
  set_wins_a: assert property (@(posedge clk_in) disable iff (rst_in)
    roll && flag_clear_in |=> overflow_flag_out)
    else $error("clear beat rollover");

  // Edge tracker rearms whenever the internal source is chosen
  edge_rearm_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !ctrl_in.source_select |=> edge_q == GTC_ARM)
    else $error("edge tracker not rearmed");

  // Gate disabled means the on bit alone decides
  gate_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl_in.counter_on && !ctrl_in.gate_enable |-> run)
    else $error("gate acted while disabled");

  // Invert set and gate low blocks counting
  gate_high_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl_in.gate_enable && ctrl_in.gate_invert && !gate_src |-> !run)
    else $error("counted with high gate low");

  // Comparator source with the wrong level blocks counting
  gate_cmp_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl_in.gate_enable && gate_source_select_in &&
      (comparator_output_in != ctrl_in.gate_invert) |-> !run)
    else $error("comparator gate ignored");

  // Pin direction bits pass through when the crystal is off
  pin_pass_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !xtal_on |=> pin_direction_bits_out == $past(pin_direction_bits_in))
    else $error("pin direction not passed through");
endmodule

// >>> tb_top.sv
/*
  Self-checking bench for the gated timer/counter.
  Assumes gtc_pkg and gtc_far_model; inputs change on falling edges.
*/
`timescale 1ns/1ps
module tb_top
  import gtc_pkg::*;
  ;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  gtc_ctrl_t ctrl = '0;
  gtc_write_t wr = '0;
  logic gss = 1'b0, gpin = 1'b0, cmp = 1'b0, iosc = 1'b0, slp = 1'b0, fclr = 1'b0;
  logic [1:0] dir_i = 2'h1, dat_i = 2'h2, dir_o, dat_o;
  logic [7:0] hi, lo;
  logic flag, wake, xrun, ext, xtal;
  int wake_cnt = 0, wake_base = 0;
  logic [15:0] cnt;
  int errors = 0, checks_done = 0;
  assign cnt = {hi, lo};
  ////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;
  // Catches any wake pulse
  always @(posedge clk_in) if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
  gtc_far_model u_far (.clk_in(clk_in), .xtal_en_in(ctrl.crystal_osc_enable),
    .ext_out(ext), .xtal_out(xtal));
  gtc_timer u_dut (.clk_in(clk_in), .rst_in(rst_in), .ctrl_in(ctrl), .wr_in(wr),
    .gate_source_select_in(gss), .gate_input_pin_in(gpin), .comparator_output_in(cmp),
    .ext_count_input_in(ext), .crystal_clk_in(xtal), .internal_osc_in(iosc),
    .sleep_in(slp), .flag_clear_in(fclr), .pin_direction_bits_in(dir_i),
    .pin_data_in(dat_i), .count_high_byte_out(hi), .count_low_byte_out(lo),
    .overflow_flag_out(flag), .wake_out(wake), .crystal_running_out(xrun),
    .pin_direction_bits_out(dir_o), .pin_data_out(dat_o));
  ////////////////////////////////////////////////////////////
  // Compares one value
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Waits n falling edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Writes high byte then low byte, then lets outputs settle
  task automatic wr_cnt(input logic [15:0] v);
    @(negedge clk_in);
    wr = '{1'b1, 1'b0, v[15:8]};
    @(negedge clk_in);
    wr = '{1'b0, 1'b1, v[7:0]};
    @(negedge clk_in);
    wr = '0;
    tick(2);
  endtask
  // Counts increments over n clocks
  task automatic span(input int n, output logic [15:0] d);
    logic [15:0] s;
    s = cnt;
    tick(n);
    d = cnt - s;
  endtask
  // Pulses the flag clear
  task automatic clr_flag;
    @(negedge clk_in);
    fclr = 1'b1;
    @(negedge clk_in);
    fclr = 1'b0;
    tick(2);
  endtask
  // Prints counts and verdict, ends the run
  task automatic end_sim;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #50000;
    errors++;
    end_sim;
  end
  // Main sequence
  initial begin
    logic [15:0] d;
    tick(2);
    rst_in = 1'b0;
    tick(2);
    chk("rst_cnt", 16'h0000, cnt);
    wr_cnt(16'ha55a);
    chk("wr", 16'ha55a, cnt);
    // Internal source, each prescale code
    for (int p = 0; p < 4; p++) begin
      wr_cnt(16'h0000);
      ctrl.prescale_select = p[1:0];
      ctrl.counter_on = 1'b1;
      tick(8);
      span(40 << p, d);
      chk("presc", 16'd10, d);
    end
    ctrl.counter_on = 1'b0;
    tick(4);
    span(40, d);
    chk("off", 16'd0, d);
    // Gate: source, polarity, level, enable
    for (int i = 0; i < 16; i++) begin
      ctrl = '0;
      ctrl.counter_on = 1'b1;
      ctrl.gate_enable = ~i[3];
      ctrl.gate_invert = i[1];
      gss = i[2];
      gpin = i[2] ? ~i[0] : i[0];
      cmp = i[2] ? i[0] : ~i[0];
      tick(8);
      span(40, d);
      chk("gate", (i[3] || i[0] == i[1]) ? 16'd10 : 16'd0, d);
    end
    // Rollover sets a sticky flag
    ctrl = '0;
    wr_cnt(16'hfffe);
    ctrl.counter_on = 1'b1;
    tick(12);
    ctrl.counter_on = 1'b0;
    tick(3);
    chk("roll", 16'h0001, cnt);
    tick(20);
    chk("flag", 16'h0001, 16'(flag));
    clr_flag;
    chk("clr", 16'h0000, 16'(flag));
    // External source: sync or async, awake or asleep
    for (int m = 0; m < 4; m++) begin
      ctrl = '0;
      slp = 1'b0;
      wr_cnt(16'hfffd);
      clr_flag;
      wake_base = wake_cnt;
      ctrl.source_select = 1'b1;
      ctrl.sync_disable = m[0];
      ctrl.counter_on = 1'b1;
      slp = m[1];
      tick(4);
      u_far.send_pulses(5);
      tick(6);
      chk("ext", (m == 2) ? 16'hfffd : 16'h0002, cnt);
      chk("wake", (m == 3) ? 16'h0001 : 16'h0000, 16'(wake_cnt - wake_base));
    end
    // Crystal enable needs the internal oscillator
    ctrl = '0;
    slp = 1'b0;
    ctrl.crystal_osc_enable = 1'b1;
    tick(3);
    chk("xoff", 16'h0006, {11'h0, xrun, dir_o, dat_o});
    iosc = 1'b1;
    tick(3);
    chk("xon", 16'h001c, {11'h0, xrun, dir_o, dat_o});
    tick(40);
    // Crystal drives the counter: 80 ns period, 20 rises in 320 clocks
    ctrl.source_select = 1'b1;
    ctrl.counter_on = 1'b1;
    tick(16);
    span(320, d);
    chk("xcnt", 16'd20, d);
    end_sim;
  end
endmodule
